/* File: hw/daa_cfg.svh */
`ifndef DAA_CFG_SVH
`define DAA_CFG_SVH

// field positions inside the primary setup word
`define DAA_STYLE_BIT       9
`define DAA_RATIO_HI        8
`define DAA_RATIO_LO        6
`define DAA_SETUP_W         16

// widths and depths
`define DAA_NATIVE_BITS     16
`define DAA_BOOST_BITS      2
`define DAA_ACC_EXTRA       5
`define DAA_HIST_DEPTH      8
`define DAA_OUT_FIFO_DEPTH  4
`define DAA_FRAME_CNT_W     8
`define DAA_GAP_W           4
`define DAA_SAMPLE_CNT_W    6

// highest valid ratio codes per averaging style
`define DAA_ROLL_MAX_CODE   3'h3
`define DAA_NORM_MAX_CODE   3'h5

// limit status bit positions
`define DAA_STAT_A_HIGH     0
`define DAA_STAT_A_LOW      1
`define DAA_STAT_B_HIGH     2
`define DAA_STAT_B_LOW      3
`define DAA_STAT_W          4

// timing: internal sample rate in normal averaging
`define DAA_CLK_KHZ         10000
`define DAA_NA_RATE_KSPS    3000
`define DAA_NA_GAP_RAW      ((`DAA_CLK_KHZ + `DAA_NA_RATE_KSPS - 1) / `DAA_NA_RATE_KSPS)
`define DAA_NA_GAP_CYC      ((`DAA_NA_GAP_RAW < 1) ? 1 : `DAA_NA_GAP_RAW)

`endif

/* File: hw/daa_pkg.sv */
package daa_pkg;

  // conversion sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CONV = 4'h2,
    ST_GAP  = 4'h4,
    ST_SUM  = 4'h8
  } daa_state_e;

endpackage

/* File: hw/daa_fifo.sv */
`timescale 1ns/1ps
`include "daa_cfg.svh"

module daa_fifo #(
  parameter int W     = 36,
  parameter int DEPTH = `DAA_OUT_FIFO_DEPTH
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         flush,
  input  wire logic         inValid,
  input  wire logic [W-1:0] inData,
  output logic              inReady,
  output logic              outValid,
  output logic [W-1:0]      outData,
  input  wire logic         outReady
);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem [DEPTH];
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic [CW-1:0] wrIdx;
  logic          doPush;
  logic          doPop;

  // handshakes and write slot; head always sits in entry 0
  assign doPush = inValid & inReady;
  assign doPop = outValid & outReady;
  assign wrIdx = doPop ? count - CW'(1) : count;
  assign next_count = count + CW'(doPush) - CW'(doPop);

  // shift storage down on pop, write behind the last entry
  always_ff @(posedge clk) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (!rst_n) begin
        mem[i] <= '0;
      end else if (doPush && wrIdx == CW'(i)) begin
        mem[i] <= inData;
      end else if (doPop && i < DEPTH - 1) begin
        mem[i] <= mem[(i < DEPTH - 1) ? i + 1 : i];
      end
    end
  end

  // occupancy and registered flags
  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      count    <= '0;
      outValid <= 1'b0;
      inReady  <= 1'b1;
    end else begin
      count    <= next_count;
      outValid <= next_count != '0;
      inReady  <= next_count != CW'(DEPTH);
    end
  end

  assign outData = mem[0];
endmodule

/* File: hw/daa_history.sv */
`timescale 1ns/1ps
`include "daa_cfg.svh"

module daa_history #(
  parameter int W     = `DAA_NATIVE_BITS,
  parameter int DEPTH = `DAA_HIST_DEPTH,
  localparam int LW   = $clog2($clog2(DEPTH) + 1),
  localparam int SW   = W + $clog2(DEPTH)
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          load,
  input  wire logic          fill,
  input  wire logic [W-1:0]  sample,
  input  wire logic [LW-1:0] log2n,
  output logic [SW-1:0]      sum
);
  logic [W-1:0] mem [DEPTH];

  // every load shifts in; a fill load copies into all entries
  always_ff @(posedge clk) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (!rst_n) begin
        mem[i] <= '0;
      end else if (load && (fill || i == 0)) begin
        mem[i] <= sample;
      end else if (load) begin
        mem[i] <= mem[(i > 0) ? i - 1 : 0];
      end
    end
  end

  // sum of the newest 2**log2n entries
  always_comb begin
    sum = '0;
    for (int i = 0; i < DEPTH; i++) begin
      if (i < (1 << log2n)) begin
        sum = sum + SW'(mem[i]);
      end
    end
  end

  chk_fill_entries: assert property (@(posedge clk) disable iff (!rst_n)
    load && fill |=> mem[DEPTH-1] == $past(sample) && mem[0] == $past(sample))
    else $error("fill load did not reach every history entry");

  chk_shift_order: assert property (@(posedge clk) disable iff (!rst_n)
    load && !fill |=> mem[1] == $past(mem[0]) && mem[0] == $past(sample))
    else $error("history did not shift on a new result");
endmodule

/* File: hw/daa_core.sv */
`timescale 1ns/1ps
`include "daa_cfg.svh"

// Notes on behaviour
// - rolling mode: style bit set, ratio valid
// - rolling keeps history; one output per conversion
// - history holds eight entries per channel
// - first result after resets fills history
// - every result shifts into history
// - rolling sums newest 2, 4, 8 entries
// - output reduced to native width
// - runs start only on select falling edge
// - extra precision adds two bits when averaging
// - limit event above upper or below lower
// - one limit pair shared by both channels
// - two status flags per channel
// - flags ORed into one common indication
// - flag pin gated by lane, enable, limits
// - flags update at each result end
// - select fall clears pin; reset clears status
// - power bit: zero normal, one shutdown
// - shutdown powers analog down, interface alive
// - shutdown leaves configuration untouched
// - style bit 9, ratio bits 8 to 6
// - normal average paces extra samples internally
module daa_core
  import daa_pkg::*;
#(
  parameter int NATIVE_W       = `DAA_NATIVE_BITS,
  parameter int HIST_DEPTH     = `DAA_HIST_DEPTH,
  parameter int OUT_FIFO_DEPTH = `DAA_OUT_FIFO_DEPTH,
  localparam int OUT_W         = NATIVE_W + `DAA_BOOST_BITS,
  localparam int ACC_W         = NATIVE_W + `DAA_ACC_EXTRA,
  localparam int HLW           = $clog2($clog2(HIST_DEPTH) + 1),
  localparam int HSW           = NATIVE_W + $clog2(HIST_DEPTH),
  localparam int FCW           = `DAA_FRAME_CNT_W
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   csPinN,
  input  wire logic                   sclkPin,
  input  wire logic [`DAA_SETUP_W-1:0] primarySetupRegister,
  input  wire logic                   extraPrecisionEnable,
  input  wire logic                   referenceSourceSelect,
  input  wire logic                   powerStateSelect,
  input  wire logic                   outputLaneSelect,
  input  wire logic                   limitPinEnable,
  input  wire logic [OUT_W-1:0]       upperLimit,
  input  wire logic [OUT_W-1:0]       lowerLimit,
  input  wire logic                   softReset,
  input  wire logic                   hardReset,
  output logic                        convStart,
  input  wire logic                   convDone,
  input  wire logic [NATIVE_W-1:0]    convResultA,
  input  wire logic [NATIVE_W-1:0]    convResultB,
  output logic [2*OUT_W-1:0]          resultData,
  output logic                        resultValid,
  input  wire logic                   resultReady,
  output logic [`DAA_STAT_W-1:0]      limitStatus,
  output logic                        secondOutputOrFlagPin,
  output logic                        flagPinOe,
  output logic                        analogPowerDown,
  output logic                        refBufferEnable,
  output logic [FCW-1:0]              lastFrameClocks
);
  localparam int GAP_CYC = `DAA_NA_GAP_CYC;
  localparam int SCW     = `DAA_SAMPLE_CNT_W;

  daa_state_e                state;
  logic [1:0]                csSync;
  logic [1:0]                sclkSync;
  logic                      csPrev;
  logic                      sclkPrev;
  logic                      csFall;
  logic                      csRise;
  logic                      sclkRise;
  logic [FCW-1:0]            frameCount;
  logic                      averagingStyleSelect;
  logic [2:0]                averagingRatioField;
  logic                      rollingActive;
  logic                      normalActive;
  logic                      boostActive;
  logic                      resetEvent;
  logic                      refPrev;
  logic                      fillPending;
  logic                      runNormal;
  logic                      runRolling;
  logic                      runBoost;
  logic [2:0]                runLog2;
  logic [SCW-1:0]            sampleCount;
  logic [SCW-1:0]            runSamples;
  logic [`DAA_GAP_W-1:0]     gapTimer;
  logic                      gapDone;
  logic                      startOk;
  logic [ACC_W-1:0]          accA;
  logic [ACC_W-1:0]          accB;
  logic                      histLoad;
  logic [HLW-1:0]            histLog2;
  logic [HSW-1:0]            histSumA;
  logic [HSW-1:0]            histSumB;
  logic [OUT_W-1:0]          pushA;
  logic [OUT_W-1:0]          pushB;
  logic                      fifoInReady;
  logic                      fifoPush;
  logic [`DAA_STAT_W-1:0]    limitNow;
  logic                      limitsValid;
  logic                      pinGate;

  // divide a sum by 2**k, keeping two extra low bits when boosted
  function automatic logic [OUT_W-1:0] avgScale(
    input logic [ACC_W-1:0] s,
    input logic [2:0]       k,
    input logic             boost
  );
    logic [ACC_W+`DAA_BOOST_BITS-1:0] t;
    t = boost ? {s, {`DAA_BOOST_BITS{1'b0}}} : {{`DAA_BOOST_BITS{1'b0}}, s};
    t = t >> k;
    return t[OUT_W-1:0];
  endfunction

  // pin synchronisers for select and serial clock
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      csSync   <= 2'h3;
      csPrev   <= 1'b1;
      sclkSync <= 2'h0;
      sclkPrev <= 1'b0;
    end else begin
      csSync   <= {csSync[0], csPinN};
      csPrev   <= csSync[1];
      sclkSync <= {sclkSync[0], sclkPin};
      sclkPrev <= sclkSync[1];
    end
  end

  assign csFall = csPrev & ~csSync[1];
  assign csRise = ~csPrev & csSync[1];
  assign sclkRise = ~sclkPrev & sclkSync[1];

  // serial clocks seen inside each frame
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frameCount      <= '0;
      lastFrameClocks <= '0;
    end else begin
      if (csFall) begin
        frameCount <= '0;
      end else if (!csSync[1] && sclkRise) begin
        frameCount <= frameCount + FCW'(1);
      end
      if (csRise) begin
        lastFrameClocks <= frameCount;
      end
    end
  end

  // setup field decode and mode qualification
  assign averagingStyleSelect = primarySetupRegister[`DAA_STYLE_BIT];
  assign averagingRatioField =
    primarySetupRegister[`DAA_RATIO_HI:`DAA_RATIO_LO];
  assign rollingActive = averagingStyleSelect && averagingRatioField != 3'h0
    && averagingRatioField <= `DAA_ROLL_MAX_CODE;
  assign normalActive = !averagingStyleSelect && averagingRatioField != 3'h0
    && averagingRatioField <= `DAA_NORM_MAX_CODE;
  assign boostActive = extraPrecisionEnable
    && (rollingActive || normalActive);
  assign resetEvent = softReset | hardReset;

  // refill request after reset or reference change; set beats clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fillPending <= 1'b1;
      refPrev     <= 1'b0;
    end else begin
      refPrev <= referenceSourceSelect;
      if (resetEvent || refPrev != referenceSourceSelect) begin
        fillPending <= 1'b1;
      end else if (histLoad) begin
        fillPending <= 1'b0;
      end
    end
  end

  // start is accepted only while idle, powered and with room for a result
  assign startOk = csFall && !powerStateSelect && fifoInReady;
  assign gapDone = gapTimer == `DAA_GAP_W'(GAP_CYC - 1);
  assign runSamples = SCW'(1) << runLog2;
  assign histLoad = state == ST_CONV && convDone;

  // conversion sequencer
  always_ff @(posedge clk) begin
    if (!rst_n || resetEvent) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (startOk) begin
            state <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (convDone && runNormal
              && sampleCount + SCW'(1) < runSamples) begin
            state <= ST_GAP;
          end else if (convDone) begin
            state <= ST_SUM;
          end
        end
        ST_GAP: begin
          if (gapDone) begin
            state <= ST_CONV;
          end
        end
        ST_SUM: begin
          if (fifoInReady) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // mode snapshot taken at each start so mid-run writes cannot tear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      runNormal  <= 1'b0;
      runRolling <= 1'b0;
      runBoost   <= 1'b0;
      runLog2    <= 3'h0;
    end else if (state == ST_IDLE && startOk) begin
      runNormal  <= normalActive;
      runRolling <= rollingActive;
      runBoost   <= boostActive;
      runLog2    <= (rollingActive || normalActive)
                    ? averagingRatioField : 3'h0;
    end
  end

  // start pulses: host edge or internal pacing in normal averaging
  always_ff @(posedge clk) begin
    if (!rst_n || resetEvent) begin
      convStart <= 1'b0;
    end else begin
      convStart <= (state == ST_IDLE && startOk)
                   || (state == ST_GAP && gapDone);
    end
  end

  // sample pacing timer and sample counter
  always_ff @(posedge clk) begin
    if (!rst_n || state == ST_IDLE) begin
      gapTimer    <= '0;
      sampleCount <= '0;
    end else begin
      gapTimer <= (state == ST_GAP && !gapDone)
                  ? gapTimer + `DAA_GAP_W'(1) : '0;
      if (histLoad) begin
        sampleCount <= sampleCount + SCW'(1);
      end
    end
  end

  // normal-average accumulators, discarded at each new start
  always_ff @(posedge clk) begin
    if (!rst_n || state == ST_IDLE) begin
      accA <= '0;
      accB <= '0;
    end else if (histLoad) begin
      accA <= accA + ACC_W'(convResultA);
      accB <= accB + ACC_W'(convResultB);
    end
  end

  // eight-entry history per channel
  assign histLog2 = runRolling ? HLW'(runLog2) : '0;

  daa_history #(
    .W     (NATIVE_W),
    .DEPTH (HIST_DEPTH)
  ) u_histA (
    .clk    (clk),
    .rst_n  (rst_n),
    .load   (histLoad),
    .fill   (fillPending),
    .sample (convResultA),
    .log2n  (histLog2),
    .sum    (histSumA)
  );

  daa_history #(
    .W     (NATIVE_W),
    .DEPTH (HIST_DEPTH)
  ) u_histB (
    .clk    (clk),
    .rst_n  (rst_n),
    .load   (histLoad),
    .fill   (fillPending),
    .sample (convResultB),
    .log2n  (histLog2),
    .sum    (histSumB)
  );

  // averaged and scaled channel results
  assign pushA = avgScale(runNormal ? accA : ACC_W'(histSumA),
                          runLog2, runBoost);
  assign pushB = avgScale(runNormal ? accB : ACC_W'(histSumB),
                          runLog2, runBoost);
  assign fifoPush = state == ST_SUM && fifoInReady;

  daa_fifo #(
    .W     (2 * OUT_W),
    .DEPTH (OUT_FIFO_DEPTH)
  ) u_outFifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .flush    (resetEvent),
    .inValid  (state == ST_SUM),
    .inData   ({pushB, pushA}),
    .inReady  (fifoInReady),
    .outValid (resultValid),
    .outData  (resultData),
    .outReady (resultReady)
  );

  // shared limit compare for both channels
  always_comb begin
    limitNow = '0;
    limitNow[`DAA_STAT_A_HIGH] = pushA > upperLimit;
    limitNow[`DAA_STAT_A_LOW]  = pushA < lowerLimit;
    limitNow[`DAA_STAT_B_HIGH] = pushB > upperLimit;
    limitNow[`DAA_STAT_B_LOW]  = pushB < lowerLimit;
  end

  assign limitsValid = upperLimit > lowerLimit;
  assign pinGate = outputLaneSelect && limitPinEnable && limitsValid;

  // status replaced at every result; any software reset clears it
  always_ff @(posedge clk) begin
    if (!rst_n || resetEvent) begin
      limitStatus <= '0;
    end else if (fifoPush) begin
      limitStatus <= limitNow;
    end
  end

  // flag pin: set at result end, cleared by select fall, set wins
  always_ff @(posedge clk) begin
    if (!rst_n || resetEvent) begin
      secondOutputOrFlagPin <= 1'b0;
      flagPinOe             <= 1'b0;
    end else begin
      flagPinOe <= pinGate;
      if (fifoPush && pinGate && |limitNow) begin
        secondOutputOrFlagPin <= 1'b1;
      end else if (csFall || !pinGate) begin
        secondOutputOrFlagPin <= 1'b0;
      end
    end
  end

  // power control touches only analog enables, never the setup
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      analogPowerDown <= 1'b0;
      refBufferEnable <= 1'b0;
    end else begin
      analogPowerDown <= powerStateSelect;
      refBufferEnable <= !referenceSourceSelect
                         && !powerStateSelect;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_start_on_fall: assert property (
    state == ST_IDLE && startOk && !resetEvent |=> convStart)
    else $error("select fall did not start a conversion");

  chk_shutdown_start: assert property (
    state == ST_IDLE && powerStateSelect |=> !convStart)
    else $error("conversion started while shut down");

  chk_power_pins: assert property (
    powerStateSelect |=> analogPowerDown && !refBufferEnable)
    else $error("analog not powered down in shutdown");

  chk_rolling_rate: assert property (
    histLoad && !runNormal && !resetEvent |=> state == ST_SUM)
    else $error("non-normal conversion gave no result");

  chk_gap_pacing: assert property (
    $rose(state == ST_GAP) && !resetEvent
      |-> !convStart [*4] ##1 convStart)
    else $error("internal sample pacing wrong");

  chk_native_width: assert property (
    fifoPush && !runBoost |-> pushA[OUT_W-1 -: 2] == 2'h0)
    else $error("unboosted result exceeds native width");

  chk_status_update: assert property (
    fifoPush && !resetEvent |=> limitStatus == $past(limitNow))
    else $error("limit status not updated at result");

  chk_status_reset: assert property (
    resetEvent |=> limitStatus == '0)
    else $error("software reset left limit status");

  chk_flag_set: assert property (
    fifoPush && pinGate && |limitNow && !resetEvent
      |=> secondOutputOrFlagPin && flagPinOe)
    else $error("limit flag pin not raised");

  chk_flag_clear: assert property (
    csFall && !fifoPush |=> !secondOutputOrFlagPin)
    else $error("select fall did not clear flag pin");

  cov_rolling: cover property (fifoPush && runRolling && runLog2 == 3'h3);
  cov_normal: cover property (fifoPush && runNormal && runBoost);
  cov_flag: cover property (fifoPush && pinGate && |limitNow);
  cov_full: cover property (state == ST_SUM && !fifoInReady);
endmodule

/* File: sim/daa_host_model.sv */
`timescale 1ns/1ps

module daa_host_model (
  input  wire logic  clk,
  output logic        csPinN,
  output logic        sclkPin,
  input  wire logic  convStart,
  output logic        convDone,
  output logic [15:0] convResultA,
  output logic [15:0] convResultB
);
  logic [15:0] ra = 16'h0;
  logic [15:0] rb = 16'h0;
  logic [2:0]  pipe = 3'h0;

  // select idles high, serial clock stands still between frames
  initial begin
    csPinN = 1'b1;
    sclkPin = 1'b0;
  end

  // converter answers each start three cycles later
  always @(posedge clk) begin
    pipe <= {pipe[1:0], convStart};
  end
  assign convDone = pipe[2];
  // result lines outside the done cycle carry the inverse value
  assign convResultA = convDone ? ra : ~ra;
  assign convResultB = convDone ? rb : ~rb;

  // one frame: select low, 18 serial clocks of 800 ns, select high
  task automatic frame(input logic [15:0] a, input logic [15:0] b);
    ra = a;
    rb = b;
    @(posedge clk) csPinN <= 1'b0;
    repeat (18) begin
      repeat (4) @(posedge clk);
      sclkPin <= 1'b1;
      repeat (4) @(posedge clk);
      sclkPin <= 1'b0;
    end
    repeat (4) @(posedge clk);
    csPinN <= 1'b1;
    repeat (20) @(posedge clk);
  endtask
endmodule

/* File: sim/testbench.sv */
`timescale 1ns/1ps

module testbench;
  import daa_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] setup = 16'h0;
  logic        boost = 1'b0;
  logic        reference_source_select = 1'b0;
  logic        pwr = 1'b0;
  logic        lane = 1'b1;
  logic        softReset = 1'b0;
  logic        hardRst = 1'b0;
  logic        alertEn = 1'b1;
  logic        resultReady = 1'b0;
  logic [17:0] upper = 18'h1f4;
  logic [17:0] lower = 18'h32;
  wire         csPinN, sclkPin, convStart, convDone;
  wire  [15:0] ra, rb;
  wire  [35:0] resultData;
  wire  [3:0]  limitStatus;
  wire  [7:0]  lfc;
  wire         resultValid, flag, oe, apd, refEn;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          nStart = 0;
  int          n0;

  daa_host_model host (.clk(clk), .csPinN(csPinN), .sclkPin(sclkPin),
    .convStart(convStart), .convDone(convDone), .convResultA(ra),
    .convResultB(rb));

  daa_core dut (.clk(clk), .rst_n(rst_n), .csPinN(csPinN),
    .sclkPin(sclkPin), .primarySetupRegister(setup),
    .extraPrecisionEnable(boost), .referenceSourceSelect(reference_source_select),
    .powerStateSelect(pwr), .outputLaneSelect(lane),
    .limitPinEnable(alertEn), .upperLimit(upper), .lowerLimit(lower),
    .softReset(softReset), .hardReset(hardRst), .convStart(convStart),
    .convDone(convDone), .convResultA(ra), .convResultB(rb),
    .resultData(resultData), .resultValid(resultValid),
    .resultReady(resultReady), .limitStatus(limitStatus),
    .secondOutputOrFlagPin(flag), .flagPinOe(oe),
    .analogPowerDown(apd), .refBufferEnable(refEn),
    .lastFrameClocks(lfc));

  // clock, 100 ns period
  initial begin
    forever #50 clk = ~clk;
  end

  // count conversion starts issued
  always @(posedge clk) begin
    if (convStart === 1'b1) begin
      nStart <= nStart + 1;
    end
  end

  task automatic chk(input string nm, input logic [35:0] exp,
                     input logic [35:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_sim;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // wait for a word, compare it, pop it
  task automatic pop(input logic [17:0] a, input logic [17:0] b);
    int i;
    i = 0;
    while (resultValid !== 1'b1 && i < 50) begin
      @(posedge clk);
      i++;
    end
    chk("valid", 36'h1, 36'(resultValid));
    chk("data", {b, a}, resultData);
    resultReady <= 1'b1;
    @(posedge clk);
    resultReady <= 1'b0;
    @(posedge clk);
  endtask

  task automatic run(input logic [15:0] s, input logic [15:0] a,
                     input logic [15:0] b);
    setup <= s;
    host.frame(a, b);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // watchdog
  initial begin
    wt(20000);
    n_mismatch++;
    end_sim;
  end

  // main sequence
  initial begin
    wt(20);
    rst_n <= 1'b1;
    wt(3);
    chk("oe", 36'h1, 36'(oe));
    run(16'h02c0, 100, 120);
    pop(100, 120);
    chk("clocks", 36'd18, 36'(lfc));
    run(16'h0240, 200, 40);
    pop(150, 80);
    run(16'h0280, 300, 40);
    pop(175, 80);
    boost <= 1'b1;
    run(16'h0240, 400, 40);
    pop(1400, 160);
    chk("status", 36'h1, 36'(limitStatus));
    chk("flag", 36'h1, 36'(flag));
    run(16'h0200, 600, 10);
    pop(600, 10);
    chk("status", 36'h9, 36'(limitStatus));
    pwr <= 1'b1;
    wt(3);
    chk("pdown", 36'h1, 36'(apd));
    chk("refen", 36'h0, 36'(refEn));
    n0 = nStart;
    host.frame(16'h1, 16'h1);
    chk("starts", 36'(n0), 36'(nStart));
    chk("flag", 36'h0, 36'(flag));
    chk("status", 36'h9, 36'(limitStatus));
    pwr <= 1'b0;
    wt(3);
    chk("pdown", 36'h0, 36'(apd));
    chk("refen", 36'h1, 36'(refEn));
    wt(20);
    lane <= 1'b0;
    wt(3);
    chk("oe", 36'h0, 36'(oe));
    lane <= 1'b1;
    alertEn <= 1'b0;
    wt(3);
    chk("oe", 36'h0, 36'(oe));
    alertEn <= 1'b1;
    softReset <= 1'b1;
    wt(1);
    softReset <= 1'b0;
    wt(3);
    chk("status", 36'h0, 36'(limitStatus));
    run(16'h02c0, 7, 9);
    pop(28, 36);
    hardRst <= 1'b1;
    wt(1);
    hardRst <= 1'b0;
    wt(3);
    chk("status", 36'h0, 36'(limitStatus));
    run(16'h02c0, 11, 3);
    pop(44, 12);
    reference_source_select <= 1'b1;
    run(16'h02c0, 15, 1);
    pop(60, 4);
    // fill the output buffer until a start is refused, then drain
    n0 = nStart;
    for (int i = 1; i <= 5; i++) begin
      run(16'h0200, 16'(i), 16'(i));
    end
    chk("starts", 36'(n0 + 4), 36'(nStart));
    for (int i = 1; i <= 4; i++) begin
      pop(18'(i), 18'(i));
    end
    chk("valid", 36'h0, 36'(resultValid));
    run(16'h0300, 40, 70);
    pop(40, 70);
    n0 = nStart;
    run(16'h0040, 50, 60);
    pop(200, 240);
    chk("starts", 36'(n0 + 2), 36'(nStart));
    end_sim;
  end
endmodule
